// ### rtl/tcci_pkg.sv
// Constants, register map and carrier types for the 8-bit timer block
// Assumes one system clock; the CPU bus and interrupt controller share it
package tcci_pkg;

    // Address map, data-space byte offsets
    localparam logic [7:0] IO_SPACE_BASE = 8'h20;
    localparam logic [7:0] OFS_FLAGS     = 8'h37;
    localparam logic [7:0] OFS_MASK      = 8'h70;
    localparam logic [7:0] OFS_CTRL_A    = 8'hB0;
    localparam logic [7:0] OFS_CTRL_B    = 8'hB1;
    localparam logic [7:0] OFS_COUNT     = 8'hB2;
    localparam logic [7:0] OFS_CMP_A     = 8'hB3;
    localparam logic [7:0] OFS_CMP_B     = 8'hB4;

    // Reset values
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [2:0] RST_FLAGS     = 3'h0;

    // Field positions in the first control register
    localparam int COM_A_MSB     = 7;
    localparam int COM_A_LSB     = 6;
    localparam int COM_B_MSB     = 5;
    localparam int COM_B_LSB     = 4;
    localparam int WGM_LO_MSB    = 1;
    localparam int WGM_LO_LSB    = 0;
    localparam logic [7:0] CTRL_A_MASK = 8'hF3;

    // Field positions in the second control register
    localparam int BIT_FORCE_A   = 7;
    localparam int BIT_FORCE_B   = 6;
    localparam int BIT_WGM_HI    = 3;
    localparam int CS_MSB        = 2;
    localparam int CS_LSB        = 0;

    // Flag and mask bit positions
    localparam int FLAG_OVF      = 0;
    localparam int FLAG_CMP_A    = 1;
    localparam int FLAG_CMP_B    = 2;

    // Counter limits
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_ONE    = 8'h01;

    // Clock select codes
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV32   = 3'h3;
    localparam logic [2:0] CS_DIV64   = 3'h4;
    localparam logic [2:0] CS_DIV128  = 3'h5;
    localparam logic [2:0] CS_DIV256  = 3'h6;
    localparam logic [2:0] CS_DIV1024 = 3'h7;
    localparam int PRESC_W = 10;

    // Waveform mode codes
    localparam logic [2:0] WGM_NORMAL   = 3'h0;
    localparam logic [2:0] WGM_PC_MAX   = 3'h1;
    localparam logic [2:0] WGM_CLEAR    = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_TOP   = 3'h5;
    localparam logic [2:0] WGM_FAST_TOP = 3'h7;

    // Compare output mode codes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // CPU register access, one request per cycle
    typedef struct packed {
        logic [7:0] addr;       // Byte offset
        logic       io_space;   // Offset is an I/O-space offset
        logic       wr;         // Write strobe
        logic       rd;         // Read strobe
        logic [7:0] wdata;      // Write data
    } tcci_bus_req_t;

    // Waveform unit steering
    typedef struct packed {
        logic       fast_pwm;   // Fast PWM mode
        logic       phase_pwm;  // Phase correct PWM mode
        logic       toggle_ok;  // Toggle allowed in PWM modes
        logic [1:0] com;        // Compare output mode
    } tcci_wave_ctl_t;

    // Counting direction, one-hot
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } tcci_dir_t;

endpackage : tcci_pkg

// ### rtl/tcci_wave.sv
// Waveform unit for one compare channel
// Assumes match, bottom and force are one-cycle pulses from the timer core
`timescale 1ns/100ps
module tcci_wave
#(
    parameter logic RST_LEVEL = 1'b0
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Steering and events
    input  tcci_pkg::tcci_wave_ctl_t      ctl,
    input  wire logic                     match,
    input  wire logic                     force_hit,
    input  wire logic                     bottom,
    input  wire logic                     counting_down,
    // Wave level
    output logic                          wave
);
    import tcci_pkg::*;

    logic next_wave;    // Level after this cycle

    // Output decision per mode
    always_comb
    begin
        next_wave = wave;
        if (ctl.phase_pwm)
        begin
            // Up-count and down-count matches act oppositely
            if (match)
            begin
                unique case (ctl.com)
                    COM_OFF:    next_wave = wave;
                    COM_TOGGLE: next_wave = ctl.toggle_ok ? ~wave : wave;
                    COM_CLEAR:  next_wave = counting_down;
                    COM_SET:    next_wave = ~counting_down;
                endcase
            end
        end
        else if (ctl.fast_pwm)
        begin
            // Bottom wins over a match at top
            if (bottom)
            begin
                if (ctl.com == COM_CLEAR)
                    next_wave = 1'b1;
                else if (ctl.com == COM_SET)
                    next_wave = 1'b0;
            end
            else if (match)
            begin
                unique case (ctl.com)
                    COM_OFF:    next_wave = wave;
                    COM_TOGGLE: next_wave = ctl.toggle_ok ? ~wave : wave;
                    COM_CLEAR:  next_wave = 1'b0;
                    COM_SET:    next_wave = 1'b1;
                endcase
            end
        end
        else if (match || force_hit)
        begin
            // Non-PWM: real or forced match, mode read now
            unique case (ctl.com)
                COM_OFF:    next_wave = wave;
                COM_TOGGLE: next_wave = ~wave;
                COM_CLEAR:  next_wave = 1'b0;
                COM_SET:    next_wave = 1'b1;
            endcase
        end
    end

    // Wave level register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wave <= RST_LEVEL;
        else
            wave <= next_wave;
    end

endmodule : tcci_wave

// ### rtl/tcci_timer.sv
// 8-bit timer/counter with two compare channels and interrupt flags
// Assumes the CPU bus, global enable and vector acknowledges share CLK
`timescale 1ns/100ps
module tcci_timer
(
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    // CPU register access
    input  tcci_pkg::tcci_bus_req_t       BUS_REQ,
    output logic [7:0]                    BUS_RDATA,
    // Interrupt handshake with the CPU
    input  wire logic                     GLOBAL_IE,
    input  wire logic [2:0]               IRQ_ACK,
    output logic [2:0]                    IRQ_REQ,
    // Wave outputs
    output logic                          WAVE_OUT_A,
    output logic                          WAVE_OUT_B
);
    import tcci_pkg::*;

    // Registers
    logic [7:0]           ctrl_a;          // Compare output modes, low mode bits
    logic                 wgm_hi;          // Waveform mode high bit
    logic [2:0]           clk_sel;         // Clock select field
    logic [7:0]           count;           // Counter value
    logic [7:0]           cmp_a;           // Compare value A
    logic [7:0]           cmp_b;           // Compare value B
    logic [2:0]           irq_mask;        // Interrupt enables
    logic [2:0]           flags;           // Interrupt flags
    tcci_dir_t            dir;             // Counting direction
    logic                 block;           // Match blocked after counter write
    logic [PRESC_W-1:0]   presc;           // Free-running prescaler

    // Decoded access
    logic [7:0]           eff_addr;        // Data-space address
    logic                 wr_ctrl_a;
    logic                 wr_ctrl_b;
    logic                 wr_count;
    logic                 wr_cmp_a;
    logic                 wr_cmp_b;
    logic                 wr_mask;
    logic                 wr_flags;
    logic [7:0]           rd_mux;

    // Mode decode and events
    logic [2:0]           wgm;
    logic                 fast_pwm;
    logic                 phase_pwm;
    logic                 clear_mode;
    logic [7:0]           top;
    logic                 tick;
    logic                 match_a;
    logic                 match_b;
    logic                 force_a;
    logic                 force_b;
    logic                 ovf_evt;
    logic                 bottom_evt;
    logic [7:0]           next_count;
    tcci_dir_t            next_dir;
    logic [2:0]           next_flags;
    tcci_wave_ctl_t       ctl_a;
    tcci_wave_ctl_t       ctl_b;

    // I/O-space offsets sit 0x20 below data-space ones
    assign eff_addr = BUS_REQ.io_space ? ({2'b00, BUS_REQ.addr[5:0]} + IO_SPACE_BASE)
                                       : BUS_REQ.addr;

    // Write strobes per register
    assign wr_ctrl_a = BUS_REQ.wr && (eff_addr == OFS_CTRL_A);
    assign wr_ctrl_b = BUS_REQ.wr && (eff_addr == OFS_CTRL_B);
    assign wr_count  = BUS_REQ.wr && (eff_addr == OFS_COUNT);
    assign wr_cmp_a  = BUS_REQ.wr && (eff_addr == OFS_CMP_A);
    assign wr_cmp_b  = BUS_REQ.wr && (eff_addr == OFS_CMP_B);
    assign wr_mask   = BUS_REQ.wr && (eff_addr == OFS_MASK);
    assign wr_flags  = BUS_REQ.wr && (eff_addr == OFS_FLAGS);

    // Mode decode
    assign wgm       = {wgm_hi, ctrl_a[WGM_LO_MSB:WGM_LO_LSB]};
    assign fast_pwm  = (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_TOP);
    assign phase_pwm = (wgm == WGM_PC_MAX) || (wgm == WGM_PC_TOP);
    assign clear_mode = (wgm == WGM_CLEAR);
    assign top       = wgm_hi ? cmp_a : CNT_MAX;

    // Force strobes act only outside PWM modes
    assign force_a = wr_ctrl_b && BUS_REQ.wdata[BIT_FORCE_A] && !fast_pwm && !phase_pwm;
    assign force_b = wr_ctrl_b && BUS_REQ.wdata[BIT_FORCE_B] && !fast_pwm && !phase_pwm;

    // Real matches only on ticks and not right after a write
    assign match_a = tick && !block && !wr_count && (count == cmp_a);
    assign match_b = tick && !block && !wr_count && (count == cmp_b);

    // Prescaler runs freely from reset
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            presc <= '0;
        else
            presc <= presc + 1'b1;
    end

    // Timer tick from the clock select field
    always_comb
    begin
        unique case (clk_sel)
            CS_STOP:    tick = 1'b0;                // Counter stopped
            CS_DIV1:    tick = 1'b1;
            CS_DIV8:    tick = &presc[2:0];
            CS_DIV32:   tick = &presc[4:0];
            CS_DIV64:   tick = &presc[5:0];
            CS_DIV128:  tick = &presc[6:0];
            CS_DIV256:  tick = &presc[7:0];
            CS_DIV1024: tick = &presc[9:0];
        endcase
    end

    // Next counter value, direction and overflow per mode
    always_comb
    begin
        next_count = count;
        next_dir   = dir;
        ovf_evt    = 1'b0;
        bottom_evt = 1'b0;
        if (tick && !wr_count)
        begin
            if (phase_pwm)
            begin
                unique case (dir)
                    DIR_UP:
                    begin
                        if (count == top)
                        begin
                            next_dir   = DIR_DOWN;
                            next_count = 8'(count - CNT_ONE);
                        end
                        else
                            next_count = 8'(count + CNT_ONE);
                    end
                    DIR_DOWN:
                    begin
                        // Turning at zero raises overflow
                        if (count == CNT_BOTTOM)
                        begin
                            next_dir   = DIR_UP;
                            next_count = 8'(count + CNT_ONE);
                            ovf_evt    = 1'b1;
                        end
                        else
                            next_count = 8'(count - CNT_ONE);
                    end
                    default: next_dir = DIR_UP;
                endcase
            end
            else if (fast_pwm)
            begin
                // Wrap at top to bottom
                next_dir = DIR_UP;
                if (count == top)
                begin
                    next_count = CNT_BOTTOM;
                    ovf_evt    = 1'b1;
                    bottom_evt = 1'b1;
                end
                else
                    next_count = 8'(count + CNT_ONE);
            end
            else
            begin
                // Normal and clear-on-match: overflow at max only
                next_dir = DIR_UP;
                ovf_evt  = (count == CNT_MAX);
                if (clear_mode && (count == cmp_a))
                    next_count = CNT_BOTTOM;
                else
                    next_count = 8'(count + CNT_ONE);
            end
        end
    end

    // Counter and direction; software write wins
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            count <= RST_REG;
            dir   <= DIR_UP;
        end
        else if (wr_count)
            count <= BUS_REQ.wdata;
        else
        begin
            count <= next_count;                    // Holds while stopped
            dir   <= next_dir;
        end
    end

    // Match blocking after a counter write
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            block <= 1'b0;
        else if (wr_count)
            block <= 1'b1;
        else if (tick)
            block <= 1'b0;
    end

    // Configuration registers
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl_a   <= RST_REG;
            wgm_hi   <= 1'b0;
            clk_sel  <= CS_STOP;
            cmp_a    <= RST_REG;
            cmp_b    <= RST_REG;
            irq_mask <= RST_FLAGS;
        end
        else
        begin
            if (wr_ctrl_a)
                ctrl_a <= BUS_REQ.wdata & CTRL_A_MASK;
            if (wr_ctrl_b)
            begin
                // Force bits are strobes and are not stored
                wgm_hi  <= BUS_REQ.wdata[BIT_WGM_HI];
                clk_sel <= BUS_REQ.wdata[CS_MSB:CS_LSB];
            end
            if (wr_cmp_a)
                cmp_a <= BUS_REQ.wdata;
            if (wr_cmp_b)
                cmp_b <= BUS_REQ.wdata;
            if (wr_mask)
                irq_mask <= BUS_REQ.wdata[2:0];
        end
    end

    // Flags: hardware set wins over write-one or vector clear
    always_comb
    begin
        next_flags = flags & ~IRQ_ACK;
        if (wr_flags)
            next_flags = next_flags & ~BUS_REQ.wdata[2:0];
        if (ovf_evt)
            next_flags[FLAG_OVF] = 1'b1;
        if (match_a)
            next_flags[FLAG_CMP_A] = 1'b1;
        if (match_b)
            next_flags[FLAG_CMP_B] = 1'b1;
    end

    // Flag register; forced matches never reach it
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            flags <= RST_FLAGS;
        else
            flags <= next_flags;
    end

    // Interrupt requests gated by mask and global enable
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            IRQ_REQ <= RST_FLAGS;
        else
            IRQ_REQ <= irq_mask & flags & {3{GLOBAL_IE}};
    end

    // Read multiplexer; reserved bits read zero
    always_comb
    begin
        case (eff_addr)
            OFS_CTRL_A: rd_mux = ctrl_a;
            OFS_CTRL_B: rd_mux = {4'h0, wgm_hi, clk_sel};   // Force bits read 0
            OFS_COUNT:  rd_mux = count;
            OFS_CMP_A:  rd_mux = cmp_a;
            OFS_CMP_B:  rd_mux = cmp_b;
            OFS_MASK:   rd_mux = {5'h00, irq_mask};
            OFS_FLAGS:  rd_mux = {5'h00, flags};
            default:    rd_mux = 8'h00;
        endcase
    end

    // Read data register, held between reads
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            BUS_RDATA <= RST_REG;
        else if (BUS_REQ.rd)
            BUS_RDATA <= rd_mux;
    end

    // Waveform steering per channel
    assign ctl_a = '{fast_pwm: fast_pwm, phase_pwm: phase_pwm, toggle_ok: wgm_hi,
                     com: ctrl_a[COM_A_MSB:COM_A_LSB]};
    assign ctl_b = '{fast_pwm: fast_pwm, phase_pwm: phase_pwm, toggle_ok: 1'b0,
                     com: ctrl_a[COM_B_MSB:COM_B_LSB]};

    // Channel A waveform
    tcci_wave u_wave_a (
        .clk           (CLK),
        .rst           (SYS_RST),
        .ctl           (ctl_a),
        .match         (match_a),
        .force_hit     (force_a),
        .bottom        (bottom_evt),
        .counting_down (dir == DIR_DOWN),
        .wave          (WAVE_OUT_A)
    );

    // Channel B waveform, forced strobe included
    tcci_wave u_wave_b (
        .clk           (CLK),
        .rst           (SYS_RST),
        .ctl           (ctl_b),
        .match         (match_b),
        .force_hit     (force_b),
        .bottom        (bottom_evt),
        .counting_down (dir == DIR_DOWN),
        .wave          (WAVE_OUT_B)
    );

    // Checks on this block's behaviour
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_force_pwm_ignored:
        assert property ((wr_ctrl_b && BUS_REQ.wdata[BIT_FORCE_B] && (fast_pwm || phase_pwm)
                          && !match_b && !bottom_evt) |=> $stable(WAVE_OUT_B))
        else $error("force compare B changed output in PWM mode");
    a_force_sets_wave:
        assert property ((force_b && ctrl_a[COM_B_MSB:COM_B_LSB] == COM_SET) |=> WAVE_OUT_B)
        else $error("forced compare B with set mode left output low");
    a_force_no_flag:
        assert property ((force_b && !match_b && !IRQ_ACK[FLAG_CMP_B])
                         |=> flags[FLAG_CMP_B] == $past(flags[FLAG_CMP_B]))
        else $error("forced compare B changed its flag");
    a_force_reads_zero:
        assert property ((BUS_REQ.rd && eff_addr == OFS_CTRL_B) |=> BUS_RDATA[7:6] == 2'b00)
        else $error("force bits read as nonzero");
    a_div8_spacing:
        assert property ((clk_sel == CS_DIV8 && tick)
                         |=> (!tick || clk_sel != CS_DIV8)[*7] ##1 (tick || clk_sel != CS_DIV8))
        else $error("divide by 8 tick spacing wrong");
    a_stopped_holds:
        assert property ((clk_sel == CS_STOP && !wr_count) |=> count == $past(count))
        else $error("counter moved while stopped");
    a_write_blocks:
        assert property (wr_count |=> block && !match_a && !match_b)
        else $error("match not blocked after counter write");
    a_flag_b_set:
        assert property (match_b |=> flags[FLAG_CMP_B] ##1 (IRQ_REQ[FLAG_CMP_B] ==
                         $past(irq_mask[FLAG_CMP_B] && GLOBAL_IE)))
        else $error("compare B match did not raise flag and request");
    a_flag_b_w1c:
        assert property ((wr_flags && BUS_REQ.wdata[FLAG_CMP_B] && !match_b)
                         |=> !flags[FLAG_CMP_B])
        else $error("write one did not clear compare B flag");
    a_irq_gate:
        assert property (IRQ_REQ[FLAG_CMP_B] |-> $past(irq_mask[FLAG_CMP_B] && GLOBAL_IE
                         && flags[FLAG_CMP_B]))
        else $error("compare B request without mask, enable and flag");

    c_forced_b: cover property (force_b ##1 $changed(WAVE_OUT_B));
    c_ovf_irq:  cover property (ovf_evt ##2 IRQ_REQ[FLAG_OVF]);
    c_pc_turn:  cover property (phase_pwm && dir == DIR_DOWN ##[1:600] ovf_evt);

endmodule : tcci_timer

// ### verif/tcci_timer_tb.sv
// Self-checking bench for the 8-bit timer block: registers, prescaler, flags, waves
// Assumes the package and design files are compiled first; the bench drives all ports
`timescale 1ns/100ps
module tcci_timer_tb;
    import tcci_pkg::*;

    // Design-facing signals
    logic          CLK;
    logic          SYS_RST;
    logic          GLOBAL_IE;
    logic [2:0]    IRQ_ACK;
    logic [2:0]    IRQ_REQ;
    logic [7:0]    rdata;
    logic          wa;
    logic          wb;
    tcci_bus_req_t req;
    // Bench state
    logic [7:0]    v;
    logic [7:0]    d;
    logic [7:0]    tg;
    logic [7:0]    ca;
    logic [7:0]    cb;
    logic          ea;
    logic          eb;
    int            fail_count;
    int            cmp_count;
    // Divider per clock select code
    localparam int DIV[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    localparam logic [7:0] OFS[7] = '{OFS_FLAGS, OFS_MASK, OFS_CTRL_B, OFS_COUNT,
                                      OFS_CMP_A, OFS_CMP_B, 8'h55};
    localparam logic [7:0] RW[4] = '{OFS_CMP_A, OFS_CMP_B, OFS_COUNT, OFS_MASK};

    tcci_timer uut (.CLK(CLK), .SYS_RST(SYS_RST), .BUS_REQ(req), .BUS_RDATA(rdata),
                    .GLOBAL_IE(GLOBAL_IE), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ),
                    .WAVE_OUT_A(wa), .WAVE_OUT_B(wb));

    // 100 ns clock
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Byte compare
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One register access, strobe held a single cycle; read data lands in v
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] dat,
                       input logic io = 1'b0);
        @(negedge CLK);
        req = '{a, io, w, !w, dat};
        @(negedge CLK);
        req = '0;
        v = rdata;
    endtask : bus

    // Verdict and end of run
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        summarize();
    end

    // Main sequence
    initial
    begin
        fail_count = 0;
        cmp_count  = 0;
        void'($urandom(32'hF9EE));
        req = '0;
        GLOBAL_IE = 1'b0;
        IRQ_ACK = 3'h0;
        SYS_RST = 1'b1;
        repeat (10) @(posedge CLK);
        @(negedge CLK) SYS_RST = 1'b0;
        // Reset values, unmapped place, flags through the I/O window
        foreach (OFS[i])
        begin
            bus(OFS[i], 1'b0, 8'h00);
            chk("reset value", 8'h00, v);
        end
        bus(8'h17, 1'b0, 8'h00, 1'b1);
        chk("io flags", 8'h00, v);
        // Random write and read back, counter stopped
        foreach (RW[i])
        begin
            d = 8'($urandom);
            bus(RW[i], 1'b1, d);
            bus(RW[i], 1'b0, 8'h00);
            chk("readback", (RW[i] == OFS_MASK) ? (d & 8'h07) : d, v);
        end
        // Every divider: two ticks in a window of two periods
        for (int cs = 1; cs < 8; cs++)
        begin
            bus(OFS_COUNT, 1'b1, 8'h00);
            bus(OFS_CTRL_B, 1'b1, 8'(cs));
            repeat (2 * DIV[cs] - 2) @(negedge CLK);
            bus(OFS_CTRL_B, 1'b1, {5'h0, CS_STOP});
            bus(OFS_COUNT, 1'b0, 8'h00);
            chk("prescaled count", 8'h02, v);
        end
        // Overflow, compare A, compare B: flag, interrupt, wave, clear
        ca = 8'h10 + 8'($urandom % 96);
        cb = ca + 8'h40;
        ea = 1'b0;
        eb = 1'b0;
        bus(OFS_CMP_A, 1'b1, ca);
        bus(OFS_CMP_B, 1'b1, cb);
        bus(OFS_CTRL_A, 1'b1, 8'h50);
        for (int ch = 0; ch < 3; ch++)
        begin
            tg = (ch == 0) ? CNT_MAX : (ch == 1) ? ca : cb;
            bus(OFS_FLAGS, 1'b1, 8'h07);
            bus(OFS_MASK, 1'b1, 8'h01 << ch);
            GLOBAL_IE = 1'b0;
            bus(OFS_COUNT, 1'b1, tg - 8'h04);
            bus(OFS_CTRL_B, 1'b1, {5'h0, CS_DIV1});
            repeat (12) @(negedge CLK);
            bus(OFS_CTRL_B, 1'b1, {5'h0, CS_STOP});
            bus(OFS_COUNT, 1'b0, 8'h00);
            chk("count", tg + 8'h0A, v);
            bus(OFS_FLAGS, 1'b0, 8'h00);
            chk("flags", 8'h01 << ch, v);
            chk("irq masked", 8'h00, {5'h0, IRQ_REQ});
            GLOBAL_IE = 1'b1;
            repeat (2) @(negedge CLK);
            chk("irq", 8'h01 << ch, {5'h0, IRQ_REQ});
            ea ^= (ch == 1);
            eb ^= (ch == 2);
            chk("wave a", {7'h0, ea}, {7'h0, wa});
            chk("wave b", {7'h0, eb}, {7'h0, wb});
            bus(OFS_FLAGS, 1'b1, 8'h00);
            chk("irq kept", 8'h01 << ch, {5'h0, IRQ_REQ});
            if (ch == 2)
            begin
                @(negedge CLK) IRQ_ACK = 3'h4;
                @(negedge CLK) IRQ_ACK = 3'h0;
            end
            else
                bus((ch == 1) ? 8'h17 : OFS_FLAGS, 1'b1, 8'h01 << ch, ch == 1);
            repeat (2) @(negedge CLK);
            chk("irq cleared", 8'h00, {5'h0, IRQ_REQ});
        end
        // Counter written equal to compare B: first tick has no match
        bus(OFS_FLAGS, 1'b1, 8'h07);
        bus(OFS_COUNT, 1'b1, cb);
        bus(OFS_CTRL_B, 1'b1, {5'h0, CS_DIV1});
        bus(OFS_CTRL_B, 1'b1, {5'h0, CS_STOP});
        bus(OFS_FLAGS, 1'b0, 8'h00);
        chk("blocked flags", 8'h00, v);
        chk("blocked wave b", {7'h0, eb}, {7'h0, wb});
        // Forced compare B: clear from high, then set, then ignored in PWM
        bus(OFS_CTRL_A, 1'b1, 8'h20);
        bus(OFS_CTRL_B, 1'b1, 8'h40);
        chk("forced clear", 8'h00, {7'h0, wb});
        bus(OFS_FLAGS, 1'b0, 8'h00);
        chk("force flags", 8'h00, v);
        chk("force irq", 8'h00, {5'h0, IRQ_REQ});
        bus(OFS_CTRL_A, 1'b1, 8'h30);
        bus(OFS_CTRL_B, 1'b1, 8'h40);
        chk("forced set", 8'h01, {7'h0, wb});
        bus(OFS_CTRL_A, 1'b1, 8'h23);
        bus(OFS_CTRL_B, 1'b1, 8'hC8);
        chk("pwm force", 8'h01, {7'h0, wb});
        bus(OFS_CTRL_B, 1'b0, 8'h00);
        chk("force reads zero", 8'h08, v);
        bus(OFS_CTRL_B, 1'b1, 8'h00);
        // Clear-on-match: two ticks from one below compare A reach bottom
        bus(OFS_CTRL_A, 1'b1, 8'h02);
        bus(OFS_COUNT, 1'b1, ca - 8'h01);
        bus(OFS_CTRL_B, 1'b1, {5'h0, CS_DIV1});
        bus(OFS_CTRL_B, 1'b1, {5'h0, CS_STOP});
        bus(OFS_COUNT, 1'b0, 8'h00);
        chk("clear on match", 8'h00, v);
        summarize();
    end

endmodule : tcci_timer_tb
